// ---- rtl/sar_adc_control.sv ----
// control of an 8-bit successive-approximation converter, eight inputs
// assumes synchronous bus strobes and a comparator answering each cycle
//
// Behaviour
// - channel field bits 6..4 selects input
// - mode bit 1 drives comparator bias
// - start bit writes start, hardware clears
// - successive approximation, 8-bit result stored
// - end flag low during conversion, high after
// - mode register resets to 04H
// - result register read only, writes ignored
// - start may lag by sixteen main clocks
// - conversion lasts 168 main-clock periods
// - only the start bit writable singly
// - channel, bias and start in one write
// - converter stops while main clock stopped
`include "sar_adc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module sar_adc_control
	import sar_adc_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int CONV_CYCLES = `CONV_PERIODS,
	parameter int START_CYCLES = `START_PERIODS
) (
	// clock, reset and main-clock run enable
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// processor data-memory access
	input wire logic [11:0] mem_addr,
	input wire logic mem_wr,
	input wire logic mem_bit_wr,
	input wire logic [2:0] mem_bit_sel,
	input wire logic [7:0] mem_wdata,
	input wire logic mem_rd,
	output logic [7:0] mem_rdata,
	output logic mem_hit,
	// analog front end
	output logic [2:0] channel_sel,
	output logic bias_select_bit,
	output logic sample_hold,
	output logic [WIDTH-1:0] dac_code,
	input wire logic cmp_high
);
	localparam int STEP_CYCLES = CONV_CYCLES / WIDTH;
	localparam int CW = $clog2(CONV_CYCLES + 1);

	conv_state_t state_r;
	logic [7:0] mode_r;
	logic [7:0] result_r;
	logic [CW-1:0] cnt_r;
	logic soc_r;
	logic mode_sel;
	logic start_req;
	logic step_tick;

	sar_step_if #(.WIDTH(WIDTH)) st ();

	assign mode_sel = (mem_addr == `MODE_ADDR);
	// start from a byte write or a single-bit write of the start bit
	assign start_req = mode_sel && ((mem_wr && mem_wdata[`BIT_SOC])
		|| (mem_bit_wr && mem_bit_sel == 3'(`BIT_SOC)
		&& mem_wdata[0]));

	// control fields: whole-byte writes only, bits 7 and 0 held zero
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mode_r <= `MODE_RESET;
		end else if (clk_en && mode_sel && mem_wr) begin
			mode_r <= mem_wdata & `MODE_WMASK;
		end
	end

	// start bit: set by software, cleared by hardware once taken
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			soc_r <= 1'b0;
		end else if (clk_en) begin
			if (start_req) begin
				soc_r <= 1'b1;
			end else if (state_r == ST_WAIT) begin
				soc_r <= 1'b0;
			end
		end
	end

	// sequencer; clk_en low (main clock stopped) freezes everything
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_r <= ST_IDLE;
			cnt_r <= '0;
		end else if (clk_en) begin
			if (start_req) begin
				state_r <= ST_WAIT;
				cnt_r <= CW'(START_CYCLES - 1);
			end else begin
				unique case (state_r)
					ST_IDLE: begin
						cnt_r <= '0;
					end
					ST_WAIT: begin
						if (cnt_r == '0) begin
							state_r <= ST_CONV;
							cnt_r <= CW'(CONV_CYCLES - 1);
						end else begin
							cnt_r <= cnt_r - 1'b1;
						end
					end
					ST_CONV: begin
						if (cnt_r == '0) begin
							state_r <= ST_IDLE;
						end else begin
							cnt_r <= cnt_r - 1'b1;
						end
					end
					default: begin
						state_r <= ST_IDLE;
					end
				endcase
			end
		end
	end

	// one comparator decision in the first cycle of each bit slot; counting from
	// the top slot gives all eight decisions before the capture cycle
	assign step_tick = (state_r == ST_CONV) && (cnt_r != '0)
		&& (((cnt_r + 1'b1) % CW'(STEP_CYCLES)) == '0);
	assign st.load = clk_en && state_r == ST_WAIT && cnt_r == '0;
	assign st.step = clk_en && step_tick;
	assign st.cmp_high = cmp_high;

	sar_approx_reg #(.WIDTH(WIDTH)) u_sar (
		.clk(clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.st(st)
	);

	// result captured when the conversion finishes; never written by bus
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			result_r <= 8'h00;
		end else if (clk_en && state_r == ST_CONV && cnt_r == '0) begin
			result_r <= 8'(st.trial);
		end
	end

	// read mux; end flag low while a start is pending or running
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mem_rdata <= 8'h00;
		end else if (clk_en && mem_rd) begin
			if (mode_sel) begin
				mem_rdata <= {1'b0, mode_r[`CH_MSB:`CH_LSB], soc_r,
					(state_r == ST_IDLE), mode_r[`BIT_BIAS], 1'b0};
			end else if (mem_addr == `RESULT_ADDR) begin
				mem_rdata <= result_r;
			end else begin
				mem_rdata <= 8'h00;
			end
		end
	end

	assign mem_hit = mode_sel || (mem_addr == `RESULT_ADDR);
	assign channel_sel = mode_r[`CH_MSB:`CH_LSB];
	assign bias_select_bit = mode_r[`BIT_BIAS];
	assign sample_hold = (state_r == ST_CONV);
	assign dac_code = st.trial;
endmodule
`default_nettype wire

// ---- rtl/sar_adc_regs.svh ----
// register offsets, field positions, reset values and timing figures
// assumes inclusion from design files only
`ifndef SAR_ADC_REGS_SVH
`define SAR_ADC_REGS_SVH

`define MODE_ADDR 12'hFD8
`define RESULT_ADDR 12'hFDA
`define MODE_RESET 8'h04
`define MODE_WMASK 8'h7A
`define BIT_BIAS 1
`define BIT_EOC 2
`define BIT_SOC 3
`define CH_LSB 4
`define CH_MSB 6
// conversion length and start latency, in main-clock periods
`define CONV_PERIODS 168
`define START_PERIODS 16

`endif

// ---- rtl/sar_adc_pkg.sv ----
// types shared by the converter control files
// assumes the register header provides the numeric constants
package sar_adc_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_CONV = 2'b10
	} conv_state_t;
endpackage

// ---- rtl/sar_step_if.sv ----
// signals between the sequencer and the approximation register
// assumes a single clock domain
`timescale 1ns/1ps
`default_nettype none
interface sar_step_if #(parameter int WIDTH = 8);
	logic load;
	logic step;
	logic cmp_high;
	logic [WIDTH-1:0] trial;
	logic done;
	modport ctrl (output load, output step, input trial, input done);
	modport sar (input load, input step, input cmp_high, output trial,
		output done);
endinterface
`default_nettype wire

// ---- rtl/sar_approx_reg.sv ----
// successive-approximation register: one result bit decided per step
// assumes comparator answer is valid when step is high
`timescale 1ns/1ps
`default_nettype none
module sar_approx_reg #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// sequencer side
	sar_step_if.sar st
);
	logic [WIDTH-1:0] trial_r;
	logic [WIDTH-1:0] probe_r;

	// probe walks from msb to lsb, keeping or dropping each trial bit
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			trial_r <= '0;
			probe_r <= '0;
		end else if (clk_en) begin
			if (st.load) begin
				trial_r <= {1'b1, {(WIDTH-1){1'b0}}};
				probe_r <= {1'b1, {(WIDTH-1){1'b0}}};
			end else if (st.step && probe_r != '0) begin
				trial_r <= (st.cmp_high ? (trial_r & ~probe_r) : trial_r)
					| (probe_r >> 1);
				probe_r <= probe_r >> 1;
			end
		end
	end

	assign st.trial = trial_r;
	assign st.done = (probe_r == '0);
endmodule
`default_nettype wire

// ---- testbench/adc_front.sv ----
// comparator and analog input model facing the converter
// assumes input voltages are given as eight 8-bit codes
`timescale 1ns/1ps
`default_nettype none
module adc_front (
	// converter side
	input wire logic [2:0] channel_sel,
	input wire logic [7:0] dac_code,
	output logic cmp_high,
	// analog levels
	input wire logic [63:0] vin
);
	// selected input compared with trial code
	assign cmp_high = dac_code > vin[channel_sel*8 +: 8];
endmodule
`default_nettype wire

// ---- testbench/sar_adc_control_monitor.sv ----
// port assertions for the converter control
// assumes one clock domain and sync reset
`timescale 1ns/1ps
`default_nettype none
module sar_adc_control_monitor (
	// watched ports
	input wire logic clk, sys_rst, clk_en, mem_wr, mem_rd, sample_hold,
	input wire logic bias_select_bit,
	input wire logic [11:0] mem_addr,
	input wire logic [7:0] mem_wdata, mem_rdata, dac_code,
	input wire logic [2:0] channel_sel
);
	logic wm, rm;
	// accepted mode write and read
	assign wm = clk_en && mem_wr && mem_addr == 12'hFD8;
	assign rm = clk_en && mem_rd && mem_addr == 12'hFD8;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	ch_follow_a: assert property (
		wm |=> channel_sel == $past(mem_wdata[6:4])) else $error("channel");
	bias_follow_a: assert property (
		wm |=> bias_select_bit == $past(mem_wdata[1])) else $error("bias");
	start_lag_a: assert property (
		wm && mem_wdata[3] |-> ##[1:40] sample_hold) else $error("no start");
	hold_len_a: assert property (
		$rose(sample_hold) |-> sample_hold[*6]) else $error("short hold");
	restart_a: assert property (
		wm && mem_wdata[3] && sample_hold |=> !sample_hold)
		else $error("no abort");
	freeze_a: assert property (
		!clk_en |=> $stable(dac_code) && $stable(sample_hold))
		else $error("not frozen");
	unused_zero_a: assert property (
		rm |=> !mem_rdata[7] && !mem_rdata[0]) else $error("bits 7/0");
	eoc_low_a: assert property (
		rm && sample_hold |=> !mem_rdata[2]) else $error("eoc high");
endmodule
bind sar_adc_control sar_adc_control_monitor i_mon (.*);
`default_nettype wire

// ---- testbench/sar_adc_control_tb.sv ----
// self-checking bench for the converter control
// assumes short counts: start 4, conversion 16 cycles
`timescale 1ns/1ps
`default_nettype none
module sar_adc_control_tb;
	logic clk = 0, sys_rst = 1, clk_en = 1, mem_wr = 0, mem_rd = 0;
	logic mem_bit_wr = 0, cmp_high, bias_select_bit, sample_hold, mem_hit;
	logic [11:0] mem_addr = 0;
	logic [2:0] mem_bit_sel = 0, channel_sel;
	logic [7:0] mem_wdata = 0, mem_rdata, dac_code, d;
	logic [63:0] vin = 0;
	int failures = 0, n_compared = 0, n, m, ch;
	sar_adc_control #(.CONV_CYCLES(16), .START_CYCLES(4)) i_sar_adc_control(.*);
	adc_front i_adc_front(.*);
	// clock and watchdog
	initial forever #2 clk = ~clk;
	initial begin
		#20000 failures++;
		stop_test();
	end
	task automatic stop_test;
		if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %0t exp %h got %h", $time, e, g);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] v, input bit b);
		mem_addr = a;
		mem_wdata = v;
		if (b) mem_bit_wr = 1;
		else mem_wr = 1;
		@(posedge clk) #1 mem_wr = 0;
		mem_bit_wr = 0;
	endtask
	task automatic rd(input logic [11:0] a);
		mem_addr = a;
		mem_rd = 1;
		@(posedge clk) #1 mem_rd = 0;
		d = mem_rdata;
	endtask
	// poll end flag, one read per cycle
	task automatic wt;
		n = 0;
		do begin
			rd(12'hFD8);
			n++;
		end while (!d[2] && n < 200);
		if (n >= 200) failures++;
	endtask
	task automatic res(input int c);
		rd(12'hFDA);
		chk(8'h01, 8'(mem_hit));
		chk(vin[c*8 +: 8], d);
	endtask
	// main sequence
	initial begin
		void'($urandom(32'hedcbbd14));
		repeat (4) @(posedge clk);
		#1 sys_rst = 0;
		rd(12'hFD8);
		chk(8'h04, d);
		rd(12'hFE0);
		chk(8'h00, d);
		for (ch = 0; ch < 8; ch++) begin
			vin = {$urandom, $urandom};
			m = ($urandom & 8'h83) | (ch << 4) | 8;
			wr(12'hFD8, 8'(m), 0);
			wt();
			chk(8'h01, 8'(n >= 16 && n <= 24));
			chk(8'(m & 8'h72 | 4), d);
			res(ch);
			wr(12'hFDA, ~d, 0);
			res(ch);
		end
		mem_bit_sel = 3'h3;
		wr(12'hFD8, 8'h09, 1);
		wt();
		res(7);
		wr(12'hFD8, 8'h00, 1);
		wr(12'hFD8, 8'h40, 1);
		rd(12'hFD8);
		chk(8'(m & 8'h72 | 4), d);
		vin = {$urandom, $urandom};
		wr(12'hFD8, 8'h18, 0);
		repeat (10) @(posedge clk);
		#1 wr(12'hFD8, 8'h38, 0);
		wt();
		res(3);
		wr(12'hFD8, 8'h58, 0);
		repeat (8) @(posedge clk);
		#1 clk_en = 0;
		repeat (20) @(posedge clk);
		#1 clk_en = 1;
		wt();
		res(5);
		stop_test();
	end
endmodule
`default_nettype wire
